// ### logic/tgm_pkg.sv
// package: register map, field layout and reset values for the transmit control and mask block
package tgm_pkg;

   // apb byte offsets, one aligned word each
   localparam logic [7:0] TGM_OFS_GLOBAL = 8'h00;
   localparam logic [7:0] TGM_OFS_ALIAS = 8'h04;
   localparam logic [7:0] TGM_OFS_MASK = 8'h08;
   localparam logic [7:0] TGM_OFS_FORMAT = 8'h0C;
   localparam logic [7:0] TGM_OFS_TXBUF = 8'h10;
   localparam logic [7:0] TGM_OFS_STATUS = 8'h14;

   // shared global control bit positions
   localparam int TGM_GC_TX_FSYNC = 12;
   localparam int TGM_GC_TX_SM = 11;
   localparam int TGM_GC_TX_SER = 10;
   localparam int TGM_GC_TX_HF = 9;
   localparam int TGM_GC_TX_BIT = 8;
   localparam logic [31:0] TGM_GC_TX_BITS = 32'h0000_1F00;
   localparam logic [31:0] TGM_GC_RX_BITS = 32'h0000_001F;
   localparam logic [31:0] TGM_GC_RESET = 32'h0000_0000;

   // transmit format configuration field layout
   localparam int TGM_FMT_ROT_LSB = 0;
   localparam int TGM_FMT_PBIT_LSB = 8;
   localparam int TGM_FMT_PAD_LSB = 13;
   localparam int TGM_FMT_RVRS = 15;
   localparam logic [31:0] TGM_FMT_WMASK = 32'h0003_FFFF;
   localparam logic [31:0] TGM_FMT_RESET = 32'h0000_0000;
   localparam logic [31:0] TGM_MASK_RESET = 32'h0000_0000;

   // pad selection codes
   localparam logic [1:0] TGM_PAD_ZERO = 2'h0;
   localparam logic [1:0] TGM_PAD_ONE = 2'h1;
   localparam logic [1:0] TGM_PAD_COPY = 2'h2;

   // serial word size and dividers
   localparam int TGM_WORD_BITS = 32;
   localparam int TGM_ROT_STEP = 4;
   localparam int TGM_BIT_DIV = 8;
   localparam int TGM_HF_DIV = 2;
   localparam int TGM_FIFO_DEPTH = 4;

   // transmit sequencer states
   typedef enum logic [1:0] {
      TGM_ST_IDLE,
      TGM_ST_LOAD,
      TGM_ST_SHIFT
   } tgm_state_e;

endpackage

// ### logic/tgm_tx_global_ctrl_and_mask.sv
// transmit global control alias, bit-keep mask unit, word fifo and serializer
//
// Function
// - alias write changes only transmit control bits 12-8 of global control
// - alias read returns the whole shared global control word
// - transmit section reset or released without touching receive control state
// - bit 12 low holds frame-sync generator in reset, high runs it
// - bit 11 low holds transmit state machine in reset, high runs it
// - bit 10 low clears transmit serializers, high makes them active
// - bit 9 low holds high-frequency divider in reset, high runs it
// - bit 8 low holds bit-clock divider in reset, high runs it
// - alias bits 4-0 mirror receive control bits, writes there ignored
// - reserved alias bits read zero and ignore writes; software writes zero
// - data bit with mask zero is replaced by the selected pad value
// - data bit with mask one passes through unchanged
// - masking and padding happen before reversal and rotation
// - pad value comes from pad select and pad source bit settings
// - pad code 0 zero, 1 one, 2 copy word bit, 3 reserved
// - pad source bit picks word bit, taken from word as written
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// small word fifo in flip-flops, index addressed
module tgm_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int LW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [LW-1:0] count_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // full and empty straight from the occupancy count
   assign in_ready = (count_q != FULL_LEVEL);
   assign out_valid = (count_q != '0);
   assign out_data = mem_q[rd_ptr_q];
   assign level = count_q;

   // storage writes need no reset, only the pointers and the count do
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // pointers wrap at the configured depth, not at a power of two
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + AW'(1);
         end
         if (push && !pop) begin
            count_q <= count_q + LW'(1);
         end else if (pop && !push) begin
            count_q <= count_q - LW'(1);
         end
      end
   end
endmodule

// top: apb register file, format unit and serial transmitter
module tgm_tx_global_ctrl_and_mask #(
   parameter int BIT_DIV = tgm_pkg::TGM_BIT_DIV,
   parameter int HF_DIV = tgm_pkg::TGM_HF_DIV,
   parameter int FIFO_DEPTH = tgm_pkg::TGM_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic tx_serial_data,
   output logic tx_serial_oe,
   output logic tx_bit_clock,
   output logic tx_hf_clock,
   output logic tx_frame_sync,
   output logic [4:0] rx_control
);
   import tgm_pkg::*;

   localparam int FLW = $clog2(FIFO_DEPTH + 1);
   localparam int BDW = $clog2(BIT_DIV + 1);
   localparam int HDW = $clog2(HF_DIV + 1);
   localparam logic [BDW-1:0] BIT_LAST = BDW'(BIT_DIV - 1);
   localparam logic [BDW-1:0] BIT_HALF = BDW'(BIT_DIV / 2);
   localparam logic [HDW-1:0] HF_LAST = HDW'(HF_DIV - 1);
   localparam logic [5:0] WORD_LAST = 6'(TGM_WORD_BITS - 1);

   // bit reversal of a whole word
   function automatic logic [31:0] reverse_word(input logic [31:0] w);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = w[31-i];
      end
      return r;
   endfunction

   // right rotation in steps of one nibble
   function automatic logic [31:0] rotate_word(input logic [31:0] w, input logic [2:0] code);
      logic [63:0] dbl;
      logic [5:0] amt;
      dbl = {w, w};
      amt = 6'(code) * 6'(TGM_ROT_STEP);
      return dbl[amt +: 32];
   endfunction

   // pad value for masked bits; the reserved code pads zero
   function automatic logic pad_value(input logic [1:0] sel, input logic copy_bit);
      logic p;
      p = 1'b0;
      unique case (sel)
         TGM_PAD_ONE: p = 1'b1;
         TGM_PAD_COPY: p = copy_bit;
         default: p = 1'b0;
      endcase
      return p;
   endfunction

   // register state
   logic [31:0] global_q;
   logic [31:0] mask_q;
   logic [31:0] format_q;
   tgm_state_e state_q;
   tgm_state_e state_d;
   logic [31:0] shift_q;
   logic [5:0] bit_cnt_q;
   logic [BDW-1:0] bit_div_q;
   logic [HDW-1:0] hf_div_q;
   logic hf_clk_q;
   logic fsync_q;
   logic sdata_q;

   // apb decode
   wire access = psel && penable;
   wire sel_global = (paddr == TGM_OFS_GLOBAL);
   wire sel_alias = (paddr == TGM_OFS_ALIAS);
   wire sel_mask = (paddr == TGM_OFS_MASK);
   wire sel_format = (paddr == TGM_OFS_FORMAT);
   wire sel_txbuf = (paddr == TGM_OFS_TXBUF);
   wire sel_status = (paddr == TGM_OFS_STATUS);
   wire mapped = sel_global | sel_alias | sel_mask | sel_format | sel_txbuf | sel_status;
   wire fifo_in_ready;
   wire buf_push = access && pwrite && sel_txbuf;
   // a buffer write stalls the bus while the fifo is full
   assign pready = !(buf_push && !fifo_in_ready);
   wire wr_en = access && pwrite && pready;
   assign pslverr = access && !mapped;

   // control bits out of the shared register
   wire fsync_run = global_q[TGM_GC_TX_FSYNC];
   wire sm_run = global_q[TGM_GC_TX_SM];
   wire ser_run = global_q[TGM_GC_TX_SER];
   wire hf_run = global_q[TGM_GC_TX_HF];
   wire bit_run = global_q[TGM_GC_TX_BIT];
   assign rx_control = global_q[4:0];

   // format fields
   wire [2:0] rot_code = format_q[TGM_FMT_ROT_LSB +: 3];
   wire [4:0] pad_src = format_q[TGM_FMT_PBIT_LSB +: 5];
   wire [1:0] pad_sel = format_q[TGM_FMT_PAD_LSB +: 2];
   wire rvrs = format_q[TGM_FMT_RVRS];

   // word fifo between the buffer register and the format unit
   wire fifo_out_valid;
   wire [31:0] fifo_out_data;
   wire [FLW-1:0] fifo_level;
   // pop in the load cycle only, so each word is taken exactly once
   wire fifo_pop = (state_q == TGM_ST_LOAD);

   tgm_fifo #(
      .WIDTH(TGM_WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .srst(srst),
      .in_valid(buf_push),
      .in_ready(fifo_in_ready),
      .in_data(pwdata),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // pad value picked from the unshifted word; reserved code pads zero
   wire pad_copy = fifo_out_data[pad_src];
   wire pad_bit = pad_value(pad_sel, pad_copy);

   // keep where mask is one, pad where zero, then reverse and rotate
   logic [31:0] masked_word;
   for (genvar g = 0; g < 32; g++) begin : g_keep
      assign masked_word[g] = mask_q[g] ? fifo_out_data[g] : pad_bit;
   end
   wire [31:0] ordered_word = rvrs ? reverse_word(masked_word) : masked_word;
   wire [31:0] formatted_word = rotate_word(ordered_word, rot_code);

   // register read mux; reserved bits come back as zero
   wire [31:0] alias_read = global_q & (TGM_GC_TX_BITS | TGM_GC_RX_BITS);
   wire status_shifting = (state_q == TGM_ST_SHIFT);
   wire status_full = !fifo_in_ready;
   wire [31:0] status_read = {24'h00_0000, 1'b0, status_shifting, fifo_out_valid, status_full,
      4'(fifo_level)};

   // read selection; the write-only buffer and unmapped offsets read zero
   wire [31:0] read_word = sel_global ? global_q :
      sel_alias ? alias_read :
      sel_mask ? mask_q :
      sel_format ? format_q :
      sel_status ? status_read : 32'h0000_0000;

   // read data registered off the setup phase address
   always_ff @(posedge clock) begin
      if (srst) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= read_word;
      end
   end

   // shared global control: full write through its own offset,
   // transmit field only through the alias
   always_ff @(posedge clock) begin
      if (srst) begin
         global_q <= TGM_GC_RESET;
      end else if (wr_en && sel_global) begin
         global_q <= pwdata & (TGM_GC_TX_BITS | TGM_GC_RX_BITS);
      end else if (wr_en && sel_alias) begin
         global_q <= (global_q & ~TGM_GC_TX_BITS) | (pwdata & TGM_GC_TX_BITS);
      end
   end

   // mask and format configuration
   always_ff @(posedge clock) begin
      if (srst) begin
         mask_q <= TGM_MASK_RESET;
         format_q <= TGM_FMT_RESET;
      end else begin
         if (wr_en && sel_mask) begin
            mask_q <= pwdata;
         end
         if (wr_en && sel_format) begin
            format_q <= pwdata & TGM_FMT_WMASK;
         end
      end
   end

   // high-frequency divider, held at zero while its run bit is low
   always_ff @(posedge clock) begin
      if (srst || !hf_run) begin
         hf_div_q <= '0;
         hf_clk_q <= 1'b0;
      end else if (hf_div_q == HF_LAST) begin
         hf_div_q <= '0;
         hf_clk_q <= !hf_clk_q;
      end else begin
         hf_div_q <= hf_div_q + HDW'(1);
      end
   end
   assign tx_hf_clock = hf_clk_q;

   // bit-clock divider; one tick per serial bit
   always_ff @(posedge clock) begin
      if (srst || !bit_run) begin
         bit_div_q <= '0;
      end else if (bit_div_q == BIT_LAST) begin
         bit_div_q <= '0;
      end else begin
         bit_div_q <= bit_div_q + BDW'(1);
      end
   end
   // bit clock high in the first half of each bit period
   wire bit_tick = bit_run && (bit_div_q == BIT_LAST);
   assign tx_bit_clock = bit_run && (bit_div_q < BIT_HALF);

   // sequencer: waits for a word, loads it, shifts it out bit by bit
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         TGM_ST_IDLE: begin
            if (fifo_out_valid && ser_run && bit_tick) begin
               state_d = TGM_ST_LOAD;
            end
         end
         TGM_ST_LOAD: begin
            state_d = TGM_ST_SHIFT;
         end
         TGM_ST_SHIFT: begin
            if (bit_tick && bit_cnt_q == WORD_LAST) begin
               state_d = TGM_ST_IDLE;
            end
         end
         // the unused fourth code of the encoding falls back to idle
         default: begin
            state_d = TGM_ST_IDLE;
         end
      endcase
      // serializer clear aborts a word in flight
      if (!ser_run) begin
         state_d = TGM_ST_IDLE;
      end
   end

   // state register held in reset while the run bit is low
   always_ff @(posedge clock) begin
      if (srst || !sm_run) begin
         state_q <= TGM_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // shift register cleared while serializers are inactive
   always_ff @(posedge clock) begin
      if (srst || !ser_run || !sm_run) begin
         shift_q <= '0;
         bit_cnt_q <= '0;
         sdata_q <= 1'b0;
      end else if (state_q == TGM_ST_LOAD) begin
         shift_q <= formatted_word;
         bit_cnt_q <= '0;
         sdata_q <= formatted_word[0];
      end else if (state_q == TGM_ST_SHIFT && bit_tick) begin
         shift_q <= {1'b0, shift_q[31:1]};
         bit_cnt_q <= bit_cnt_q + 6'(1);
         sdata_q <= shift_q[1];
      end
   end
   assign tx_serial_data = sdata_q;

   // pin driven whenever the serializers are active, even between words
   assign tx_serial_oe = ser_run;

   // frame sync marks the load of each word; generator held in reset when off
   always_ff @(posedge clock) begin
      if (srst || !fsync_run) begin
         fsync_q <= 1'b0;
      end else begin
         fsync_q <= (state_q == TGM_ST_LOAD);
      end
   end
   assign tx_frame_sync = fsync_q;

endmodule

// ### verification/test_tx_global_ctrl_and_mask.sv
// testbench: register access, alias isolation and masked serial words
`timescale 1ns/1ps
module test_tx_global_ctrl_and_mask;
   import tgm_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic tx_serial_data;
   wire logic tx_serial_oe;
   wire logic tx_bit_clock;
   wire logic tx_hf_clock;
   wire logic tx_frame_sync;
   wire logic [4:0] rx_control;
   wire logic [31:0] word;
   wire logic got;
   int n_fail = 0;
   int checked = 0;
   logic [31:0] rv;
   logic er;
   logic hv;
   logic bv;
   tgm_tx_global_ctrl_and_mask dut_u (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tx_serial_data, .tx_serial_oe, .tx_bit_clock, .tx_hf_clock,
      .tx_frame_sync, .rx_control);
   tgm_codec_model codec_u (.clock, .srst, .sdata(tx_serial_data), .fsync(tx_frame_sync),
      .word, .got);
   // 50 MHz clock
   initial begin
      forever #10 clock = ~clock;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(what, rv, exp);
   endtask
   // reference formatter: pad, mask, reverse, then rotate right
   function automatic logic [31:0] fmt(input logic [31:0] d, m, input logic [1:0] pad,
         input logic [4:0] pb, input logic rev, input logic [2:0] rot);
      logic p;
      logic [31:0] w;
      logic [31:0] r;
      p = (pad == 2'h1) || (pad == 2'h2 && d[pb]);
      w = (d & m) | (~m & {32{p}});
      for (int i = 0; i < 32; i++) r[i] = rev ? w[31 - i] : w[i];
      return (r >> (4 * rot)) | (r << (32 - 4 * rot));
   endfunction
   // load words while held, so the fifo keeps them, then release and collect
   task automatic send(input logic [31:0] d, m, input logic [1:0] pad, input logic [4:0] pb,
         input logic rev, input logic [2:0] rot, input int n);
      int nw;
      nw = n + int'(n == 4);
      apb(1'b1, TGM_OFS_ALIAS, 32'h0);
      apb(1'b1, TGM_OFS_MASK, m);
      apb(1'b1, TGM_OFS_FORMAT, {16'h0, rev, pad, pb, 5'h00, rot});
      for (int k = 0; k < n; k++) apb(1'b1, TGM_OFS_TXBUF, d + k);
      rd(TGM_OFS_STATUS, {26'h0, 1'b1, n == 4, 4'(n)}, "fifo status");
      // all but the state machine run: nothing may leave the fifo
      apb(1'b1, TGM_OFS_ALIAS, 32'h0000_1700);
      repeat (2 * TGM_BIT_DIV) @(posedge clock);
      rd(TGM_OFS_STATUS, {26'h0, 1'b1, n == 4, 4'(n)}, "held status");
      apb(1'b1, TGM_OFS_ALIAS, 32'h0000_1F00);
      // a fifth word into a full fifo stalls the bus until a word is loaded
      if (n == 4) apb(1'b1, TGM_OFS_TXBUF, d + 32'h4);
      for (int k = 0; k < nw; k++) begin
         @(posedge clock);
         while (got !== 1'b1) @(posedge clock);
         check("word", word, fmt(d + k, m, pad, pb, rev, rot));
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // hang guard, far beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      rd(TGM_OFS_GLOBAL, TGM_GC_RESET, "global reset");
      rd(TGM_OFS_MASK, TGM_MASK_RESET, "mask reset");
      rd(TGM_OFS_FORMAT, TGM_FMT_RESET, "format reset");
      apb(1'b1, TGM_OFS_GLOBAL, 32'hFFFF_FFFF);
      rd(TGM_OFS_ALIAS, 32'h0000_1F1F, "alias full");
      apb(1'b1, TGM_OFS_ALIAS, 32'h0);
      rd(TGM_OFS_GLOBAL, 32'h0000_001F, "tx only reset");
      check("rx control", {27'h0, rx_control}, 32'h1F);
      for (int b = 8; b < 13; b++) begin
         apb(1'b1, TGM_OFS_ALIAS, 32'h0000_0000 | (32'h1 << b));
         rd(TGM_OFS_ALIAS, (32'h1 << b) | 32'h1F, "alias bit");
         check("oe", {31'h0, tx_serial_oe}, 32'(b == 10));
         hv = tx_hf_clock;
         bv = tx_bit_clock;
         repeat (TGM_HF_DIV) @(posedge clock);
         check("hf clock", {31'h0, tx_hf_clock}, {31'h0, (b == 9) && !hv});
         repeat (TGM_BIT_DIV / 2 - TGM_HF_DIV) @(posedge clock);
         check("bit clock", {31'h0, tx_bit_clock}, {31'h0, (b == 8) && !bv});
      end
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped err", {31'h0, er}, 32'h1);
      apb(1'b1, TGM_OFS_GLOBAL, 32'h0);
      send(32'hA5C3_0F69, 32'hFFFF_FFFF, 2'h0, 5'h00, 1'b0, 3'h0, 1);
      send(32'hA5C3_0F69, 32'h0000_FFFF, 2'h0, 5'h00, 1'b0, 3'h0, 1);
      send(32'h1234_5678, 32'h00FF_00FF, 2'h1, 5'h00, 1'b0, 3'h0, 1);
      send(32'h8000_0001, 32'h0000_0FF0, 2'h2, 5'h1F, 1'b0, 3'h0, 1);
      send(32'h0000_0002, 32'h0000_0FF0, 2'h2, 5'h01, 1'b1, 3'h1, 4);
      send(32'hFFFF_0000, 32'h0F0F_0F0F, 2'h3, 5'h10, 1'b0, 3'h2, 1);
      test_done();
   end
endmodule

// ### verification/tgm_codec_model.sv
// partner: converter model collecting one serial word per frame pulse
`timescale 1ns/1ps
module tgm_codec_model (
   input wire logic clock,
   input wire logic srst,
   input wire logic sdata,
   input wire logic fsync,
   output logic [31:0] word,
   output logic got
);
   logic act_q;
   logic [7:0] cnt_q;
   logic [31:0] sh_q;
   wire logic [31:0] sh_d = {sdata, sh_q[31:1]};
   // lsb first, sampled mid-bit so a one-cycle pulse offset is tolerated
   always_ff @(posedge clock) begin
      got <= 1'b0;
      if (srst) begin
         act_q <= 1'b0;
         cnt_q <= 8'h00;
      end else if (fsync && !act_q) begin
         act_q <= 1'b1;
         cnt_q <= 8'h00;
      end else if (act_q) begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q[2:0] == 3'h3) begin
            sh_q <= sh_d;
         end
         if (cnt_q == 8'hFB) begin
            act_q <= 1'b0;
            got <= 1'b1;
            word <= sh_d;
         end
      end
   end
endmodule

// ### verification/tgm_tx_asserts.sv
// checker: port-level properties of the transmit control and mask block
`timescale 1ns/1ps
module tgm_tx_asserts
   import tgm_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_serial_data,
   input wire logic tx_serial_oe,
   input wire logic tx_bit_clock,
   input wire logic tx_hf_clock,
   input wire logic tx_frame_sync,
   input wire logic [4:0] rx_control
);
   logic [4:0] txb_q;
   // accepted writes that reach the transmit control bits
   wire logic wr_ok = psel && penable && pready && pwrite;
   wire logic gc_wr = wr_ok && (paddr == TGM_OFS_GLOBAL || paddr == TGM_OFS_ALIAS);
   // shadow of bits 12-8, so holds can be judged from the outside
   always_ff @(posedge clock) begin
      if (srst) begin
         txb_q <= 5'h00;
      end else if (gc_wr) begin
         txb_q <= pwdata[12:8];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   alias_read_a: assert property (psel && penable && !pwrite && paddr == TGM_OFS_ALIAS
      |-> prdata == {19'h00000, txb_q, 3'h0, rx_control}) else $error("alias read mismatch");
   rx_keep_a: assert property (!(wr_ok && paddr == TGM_OFS_GLOBAL)
      |=> $stable(rx_control)) else $error("receive control disturbed");
   oe_track_a: assert property (tx_serial_oe == txb_q[2]) else $error("oe not bit 10");
   data_clr_a: assert property (!txb_q[2] [*2] |=> !tx_serial_data)
      else $error("serial data not cleared");
   bitclk_held_a: assert property (!txb_q[0] [*2] |-> !tx_bit_clock)
      else $error("bit clock runs in reset");
   hfclk_held_a: assert property (!txb_q[1] [*2] |=> !tx_hf_clock)
      else $error("hf clock runs in reset");
   fsync_held_a: assert property (!txb_q[4] [*3] |=> !tx_frame_sync)
      else $error("frame sync while held");
   sm_held_a: assert property (!txb_q[3] [*3] |=> !tx_frame_sync)
      else $error("state machine runs in reset");
   fsync_pulse_a: assert property ($rose(tx_frame_sync) |=> !tx_frame_sync)
      else $error("frame sync too long");
endmodule

bind tgm_tx_global_ctrl_and_mask tgm_tx_asserts chk_u (.clock, .srst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_serial_data, .tx_serial_oe, .tx_bit_clock,
   .tx_hf_clock, .tx_frame_sync, .rx_control);
